// ### rtl/udci_params.svh
// Register offsets, field positions, reset values and sizes of the USB control block
`ifndef UDCI_PARAMS_SVH
`define UDCI_PARAMS_SVH

// Register window on the local bus
`define UDCI_WIN_BASE 16'h4000
`define UDCI_WIN_BYTES 16'h0030
`define UDCI_OFF_CTRL 16'h4000
`define UDCI_OFF_IEN 16'h4002
`define UDCI_OFF_ISTS 16'h4004

// Control register fields
`define UDCI_CTRL_CLK_GATE 7
`define UDCI_CTRL_ZLP 6
`define UDCI_CTRL_ENUM 5
`define UDCI_CTRL_EP4_STALL 4
`define UDCI_CTRL_EP3_STALL 3
`define UDCI_CTRL_PIN_SEL 2

// Interrupt enable and status fields
`define UDCI_IRQ_SUSPEND 7
`define UDCI_IRQ_SOF 6
`define UDCI_IRQ_EP4_TX 4
`define UDCI_IRQ_EP3_RX 3
`define UDCI_IRQ_EP2_MBOX 2
`define UDCI_IRQ_EP1_MBOX 1
`define UDCI_IRQ_UPPER 0

// Writable masks; reserved bits are dropped and read as zero
`define UDCI_CTRL_WMASK 8'hfc
`define UDCI_IEN_WMASK 8'hde
`define UDCI_ISTS_W1C 8'hde

// Reset values
`define UDCI_CTRL_RST 8'h00
`define UDCI_IEN_RST 8'h00
`define UDCI_ISTS_RST 8'h00

// Endpoint 4 transmit buffer
`define UDCI_FIFO_DEPTH 32
`define UDCI_DATA_W 8

`endif

// ### rtl/udci_pkg.sv
// Shared types of the USB control block
package udci_pkg;

    // Handshake returned to the USB engine
    typedef enum logic [1:0] {
        UDCI_HS_ACK = 2'h0,
        UDCI_HS_NAK = 2'h1,
        UDCI_HS_STALL = 2'h2
    } udci_hs_t;

    // Token answer state machine, Gray along idle-pop-settle
    typedef enum logic [1:0] {
        UDCI_ST_IDLE = 2'h0,
        UDCI_ST_POP = 2'h1,
        UDCI_ST_SETTLE = 2'h3
    } udci_fsm_t;

    // Events reported by the USB engine, one-cycle pulses
    typedef struct packed {
        logic suspend_req;
        logic sof;
        logic ep2_mbox_read;
        logic ep1_mbox_write;
    } udci_event_t;

    // Answer to a token
    typedef struct packed {
        logic valid;
        udci_hs_t hs;
        logic zero_len;
        logic has_data;
        logic [7:0] data;
    } udci_resp_t;

endpackage

// ### rtl/udci_pin_sync.sv
// Three-flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module udci_pin_sync #(
    parameter int W = 4
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } udci_sync_st_t;

    udci_sync_st_t st;
    udci_sync_st_t next_st;

    // First stage feeds only the second; a change counts once stages two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.q;
endmodule

// ### rtl/udci_fifo.sv
// Flop-based show-ahead FIFO with registered full and empty flags
`timescale 1ns/1ns
module udci_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic room;
        logic avail;
    } udci_fifo_st_t;

    udci_fifo_st_t st;
    udci_fifo_st_t next_st;
    logic push;
    logic pop;

    // Flags are stored in their port sense so ready and valid leave straight from flops
    always_comb begin
        next_st = st;
        push = in_valid_i && st.room;
        pop = out_ready_i && st.avail;
        if (push) begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_st.room = (next_st.cnt != (AW+1)'(DEPTH));
        next_st.avail = (next_st.cnt != '0);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st <= '0;
            st.room <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_o = st.room;
    assign out_valid_o = st.avail;
    assign out_data_o = st.mem[st.rd];
endmodule

// ### rtl/udci_top.sv
// USB device control, pin hand-over, token answers and first interrupt bank
`timescale 1ns/1ns
`include "udci_params.svh"
module udci_top #(
    parameter int DATA_W = `UDCI_DATA_W,
    parameter int FIFO_DEPTH = `UDCI_FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [15:0] bus_wdata_i,
    output logic [15:0] bus_rdata_o,
    output logic bus_ack_o,
    input wire logic tx_valid_i,
    input wire logic [DATA_W-1:0] tx_data_i,
    output logic tx_ready_o,
    input wire logic in_tok_ep4_i,
    input wire logic out_tok_ep3_i,
    input wire logic desc_req_i,
    input wire logic rx_valid_i,
    input wire logic [DATA_W-1:0] rx_data_i,
    output logic rx_valid_o,
    output logic [DATA_W-1:0] rx_data_o,
    output udci_pkg::udci_resp_t resp_o,
    input wire udci_pkg::udci_event_t event_i,
    input wire logic upper_irq_active_i,
    output logic usb_clock_gate_o,
    output logic pin_usb_sel_o,
    input wire logic [3:0] gpio_pin_i,
    output logic [3:0] gpio_pin_o,
    output logic [3:0] gpio_pin_oe_o,
    input wire logic [3:0] gpio_out_i,
    input wire logic [3:0] gpio_oe_i,
    output logic [3:0] gpio_in_o,
    input wire logic [3:0] usb_pin_out_i,
    input wire logic [3:0] usb_pin_oe_i,
    output logic [3:0] usb_pin_in_o,
    output logic irq_o
);
    // Whole state of the block
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ien;
        logic [7:0] ists;
        logic [15:0] rdata;
        logic ack;
        logic irq;
        logic gate;
        logic sel;
        logic [3:0] pin_o;
        logic [3:0] pin_oe;
        logic [3:0] gin;
        logic [3:0] uin;
        udci_pkg::udci_resp_t resp;
        logic rx_valid;
        logic [DATA_W-1:0] rx_data;
        udci_pkg::udci_fsm_t fsm;
        logic pop;
    } udci_st_t;

    udci_st_t st;
    udci_st_t next_st;

    logic fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic [3:0] pin_level;
    logic in_win;
    logic [15:0] off;
    logic [7:0] set_ev;
    logic [7:0] clr;
    logic [7:0] sts_rd;

    // Endpoint 4 transmit buffer; its ready back-pressures the CPU-side stream
    udci_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .in_valid_i(tx_valid_i),
        .in_data_i(tx_data_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(st.pop)
    );

    // Shared pins arrive from outside the clock domain
    udci_pin_sync #(
        .W(4)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .pin_i(gpio_pin_i),
        .level_o(pin_level)
    );

    // Address decode of the 48-byte window
    always_comb begin
        off = bus_addr_i - `UDCI_WIN_BASE;
        in_win = (bus_addr_i >= `UDCI_WIN_BASE) && (off < `UDCI_WIN_BYTES);
    end

    // Main next-state logic
    always_comb begin
        next_st = st;
        set_ev = 8'h00;
        clr = 8'h00;
        sts_rd = 8'h00;
        next_st.ack = 1'b0;
        next_st.pop = 1'b0;
        next_st.resp.valid = 1'b0;
        next_st.rx_valid = 1'b0;

        // Token handling; tokens arriving while a pop settles are not answered
        unique case (st.fsm)
            udci_pkg::UDCI_ST_IDLE: begin
                if (in_tok_ep4_i) begin
                    next_st.resp.valid = 1'b1;
                    next_st.resp.zero_len = 1'b0;
                    next_st.resp.has_data = 1'b0;
                    next_st.resp.data = '0;
                    if (st.ctrl[`UDCI_CTRL_EP4_STALL]) begin
                        next_st.resp.hs = udci_pkg::UDCI_HS_STALL;
                    end else if (!fifo_valid) begin
                        if (st.ctrl[`UDCI_CTRL_ZLP]) begin
                            next_st.resp.hs = udci_pkg::UDCI_HS_ACK;
                            next_st.resp.zero_len = 1'b1;
                            next_st.ctrl[`UDCI_CTRL_ZLP] = 1'b0;
                        end else begin
                            next_st.resp.hs = udci_pkg::UDCI_HS_NAK;
                        end
                    end else begin
                        next_st.resp.hs = udci_pkg::UDCI_HS_ACK;
                        next_st.resp.has_data = 1'b1;
                        next_st.resp.data = fifo_data;
                        next_st.pop = 1'b1;
                        next_st.fsm = udci_pkg::UDCI_ST_POP;
                        set_ev[`UDCI_IRQ_EP4_TX] = 1'b1;
                    end
                end else if (out_tok_ep3_i) begin
                    next_st.resp.valid = 1'b1;
                    next_st.resp.zero_len = 1'b0;
                    next_st.resp.has_data = 1'b0;
                    next_st.resp.data = '0;
                    if (st.ctrl[`UDCI_CTRL_EP3_STALL]) begin
                        next_st.resp.hs = udci_pkg::UDCI_HS_STALL;
                    end else begin
                        next_st.resp.hs = udci_pkg::UDCI_HS_ACK;
                        set_ev[`UDCI_IRQ_EP3_RX] = 1'b1;
                    end
                end else if (desc_req_i) begin
                    next_st.resp.valid = 1'b1;
                    next_st.resp.zero_len = 1'b0;
                    next_st.resp.has_data = 1'b0;
                    next_st.resp.data = '0;
                    if (st.ctrl[`UDCI_CTRL_ENUM]) begin
                        next_st.resp.hs = udci_pkg::UDCI_HS_ACK;
                    end else begin
                        next_st.resp.hs = udci_pkg::UDCI_HS_NAK;
                    end
                end
            end
            udci_pkg::UDCI_ST_POP: begin
                next_st.fsm = udci_pkg::UDCI_ST_SETTLE;
            end
            udci_pkg::UDCI_ST_SETTLE: begin
                // Wait one cycle so the registered empty flag is current
                next_st.fsm = udci_pkg::UDCI_ST_IDLE;
            end
            default: begin
                next_st.fsm = udci_pkg::UDCI_ST_IDLE;
            end
        endcase

        // Receive data passes only while endpoint 3 is not stalled
        if (rx_valid_i && !st.ctrl[`UDCI_CTRL_EP3_STALL]) begin
            next_st.rx_valid = 1'b1;
            next_st.rx_data = rx_data_i;
        end

        // Engine events
        set_ev[`UDCI_IRQ_SUSPEND] = event_i.suspend_req;
        set_ev[`UDCI_IRQ_SOF] = event_i.sof;
        set_ev[`UDCI_IRQ_EP2_MBOX] = event_i.ep2_mbox_read;
        set_ev[`UDCI_IRQ_EP1_MBOX] = event_i.ep1_mbox_write;

        // Register writes; reserved bits are masked and always read zero
        if (bus_wr_i && in_win) begin
            next_st.ack = 1'b1;
            if (bus_addr_i == `UDCI_OFF_CTRL) begin
                next_st.ctrl = bus_wdata_i[7:0] & `UDCI_CTRL_WMASK;
                // A zero-length reply in this cycle still clears the auto reply bit
                if (next_st.resp.valid && next_st.resp.zero_len) begin
                    next_st.ctrl[`UDCI_CTRL_ZLP] = 1'b0;
                end
            end else if (bus_addr_i == `UDCI_OFF_IEN) begin
                next_st.ien = bus_wdata_i[7:0] & `UDCI_IEN_WMASK;
            end else if (bus_addr_i == `UDCI_OFF_ISTS) begin
                clr = bus_wdata_i[7:0] & `UDCI_ISTS_W1C;
            end
        end

        // Sticky status; a new event wins over a clear in the same cycle
        next_st.ists = ((st.ists & ~clr) | set_ev) & `UDCI_ISTS_W1C;

        // Register reads; bit 0 of status mirrors the second bank
        sts_rd = st.ists;
        sts_rd[`UDCI_IRQ_UPPER] = upper_irq_active_i;
        if (bus_rd_i && in_win) begin
            next_st.ack = 1'b1;
            if (bus_addr_i == `UDCI_OFF_CTRL) begin
                next_st.rdata = {8'h00, st.ctrl};
            end else if (bus_addr_i == `UDCI_OFF_IEN) begin
                next_st.rdata = {8'h00, st.ien};
            end else if (bus_addr_i == `UDCI_OFF_ISTS) begin
                next_st.rdata = {8'h00, sts_rd};
            end else begin
                next_st.rdata = 16'h0000;
            end
        end

        // Interrupt request from enabled pending status
        next_st.irq = |(next_st.ists & next_st.ien);

        // Clock gate and pin function follow the control bits
        next_st.gate = next_st.ctrl[`UDCI_CTRL_CLK_GATE];
        next_st.sel = next_st.ctrl[`UDCI_CTRL_PIN_SEL];

        // Shared pin mux; the selected function sees the filtered input level, the other reads zero
        if (st.sel) begin
            next_st.pin_o = usb_pin_out_i;
            next_st.pin_oe = usb_pin_oe_i;
            next_st.uin = pin_level;
            next_st.gin = 4'h0;
        end else begin
            next_st.pin_o = gpio_out_i;
            next_st.pin_oe = gpio_oe_i;
            next_st.gin = pin_level;
            next_st.uin = 4'h0;
        end
    end

    // State register
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st <= '0;
            st.ctrl <= `UDCI_CTRL_RST;
            st.ien <= `UDCI_IEN_RST;
            st.ists <= `UDCI_ISTS_RST;
            st.fsm <= udci_pkg::UDCI_ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign bus_rdata_o = st.rdata;
    assign bus_ack_o = st.ack;
    assign rx_valid_o = st.rx_valid;
    assign rx_data_o = st.rx_data;
    assign resp_o = st.resp;
    assign usb_clock_gate_o = st.gate;
    assign pin_usb_sel_o = st.sel;
    assign gpio_pin_o = st.pin_o;
    assign gpio_pin_oe_o = st.pin_oe;
    assign gpio_in_o = st.gin;
    assign usb_pin_in_o = st.uin;
    assign irq_o = st.irq;
endmodule

// ### dv/udci_top_chk.sv
// Port-level assertions of the USB control block
`timescale 1ns/1ns
`include "udci_params.svh"
module udci_top_chk #(
    parameter int DATA_W = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [15:0] bus_wdata_i,
    input wire logic bus_ack_o,
    input wire logic in_tok_ep4_i,
    input wire logic out_tok_ep3_i,
    input wire logic desc_req_i,
    input wire udci_pkg::udci_resp_t resp_o,
    input wire udci_pkg::udci_event_t event_i,
    input wire logic usb_clock_gate_o,
    input wire logic pin_usb_sel_o,
    input wire logic [3:0] gpio_oe_i,
    input wire logic [3:0] gpio_pin_oe_o,
    input wire logic [3:0] gpio_in_o,
    input wire logic irq_o
);
    logic in_win;
    logic ctrl_wr;
    logic ien_wr;
    logic sof_en;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    // Window and register decode
    assign in_win = bus_addr_i >= `UDCI_WIN_BASE && bus_addr_i < `UDCI_WIN_BASE + `UDCI_WIN_BYTES;
    assign ctrl_wr = bus_wr_i && bus_addr_i == `UDCI_OFF_CTRL;
    assign ien_wr = bus_wr_i && bus_addr_i == `UDCI_OFF_IEN;
    // Shadow of the frame-start enable, so irq can be tied to its event
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sof_en <= 1'b0;
        end else if (ien_wr) begin
            sof_en <= bus_wdata_i[`UDCI_IRQ_SOF];
        end
    end
    AST_ACK_IN: assert property ((bus_wr_i || bus_rd_i) && in_win |=> bus_ack_o)
        else $error("in-window access not acknowledged");
    AST_NO_ACK_OUT: assert property ((bus_wr_i || bus_rd_i) && !in_win |=> !bus_ack_o)
        else $error("out-of-window access acknowledged");
    AST_CLK_GATE: assert property (ctrl_wr |=> usb_clock_gate_o == $past(bus_wdata_i[7]))
        else $error("clock gate does not follow control write");
    AST_PIN_SEL: assert property (ctrl_wr |=> pin_usb_sel_o == $past(bus_wdata_i[2]))
        else $error("pin select does not follow control write");
    AST_GPIO_DRIVE: assert property ($past(!pin_usb_sel_o) && $past(!reset_i) |-> gpio_pin_oe_o == $past(gpio_oe_i))
        else $error("general pins not driven from gpio side");
    AST_GPIO_QUIET: assert property ($past(pin_usb_sel_o) |-> gpio_in_o == 4'h0)
        else $error("gpio input seen while pins belong to usb");
    AST_RESP_CAUSE: assert property (resp_o.valid |-> $past(in_tok_ep4_i || out_tok_ep3_i || desc_req_i))
        else $error("answer without token");
    AST_SOF_IRQ: assert property (event_i.sof && sof_en && !ien_wr |=> irq_o)
        else $error("enabled frame event gives no interrupt");
endmodule
bind udci_top udci_top_chk #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) u_udci_top_chk (
    .core_clk_i, .reset_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i, .bus_ack_o,
    .in_tok_ep4_i, .out_tok_ep3_i, .desc_req_i, .resp_o, .event_i, .usb_clock_gate_o,
    .pin_usb_sel_o, .gpio_oe_i, .gpio_pin_oe_o, .gpio_in_o, .irq_o
);

// ### dv/udci_usb_host_model.sv
// Behavioural USB engine side: tokens, receive bytes and bus events
`timescale 1ns/1ns
module udci_usb_host_model (
    input wire logic core_clk_i,
    input wire logic rx_copy_i,
    output logic in_tok_o,
    output logic out_tok_o,
    output logic desc_req_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output udci_pkg::udci_event_t event_o
);
    // Idle levels at time zero
    initial begin
        in_tok_o = 1'b0;
        out_tok_o = 1'b0;
        desc_req_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h5a;
        event_o = '0;
    end
    // Kind 0 IN, 1 OUT with one byte ahead, 2 descriptor read
    task automatic send_token(input int k, output logic rx_seen);
        rx_seen = 1'b0;
        @(negedge core_clk_i);
        if (k == 1) begin
            rx_valid_o = 1'b1;
            @(negedge core_clk_i);
            rx_valid_o = 1'b0;
            rx_data_o = ~rx_data_o; // Released data line shows no stale byte
            rx_seen = rx_copy_i;
        end
        in_tok_o = k == 0;
        out_tok_o = k == 1;
        desc_req_o = k == 2;
        @(negedge core_clk_i);
        in_tok_o = 1'b0;
        out_tok_o = 1'b0;
        desc_req_o = 1'b0;
    endtask
    // One-cycle bus event pulse
    task automatic pulse_event(input int b);
        @(negedge core_clk_i);
        event_o = udci_pkg::udci_event_t'(4'h1 << b);
        @(negedge core_clk_i);
        event_o = '0;
    endtask
endmodule

// ### dv/udci_top_bench.sv
// Self-checking bench of the USB control block
`timescale 1ns/1ns
`include "udci_params.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module udci_top_bench;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] bus_addr_i = 16'h0000;
    logic [15:0] bus_wdata_i = 16'h0000;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic tx_valid_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic upper_irq_active_i = 1'b0;
    logic [3:0] gpio_pin_i = 4'h0;
    logic [3:0] gpio_out_i = 4'ha;
    logic [3:0] gpio_oe_i = 4'h3;
    logic [3:0] usb_pin_out_i = 4'h5;
    logic [3:0] usb_pin_oe_i = 4'hf;
    logic [15:0] bus_rdata_o;
    logic [7:0] rx_data_i, rx_byte;
    logic [3:0] gpio_pin_o, gpio_pin_oe_o, gpio_in_o, usb_pin_in_o;
    logic bus_ack_o, tx_ready_o, in_tok_ep4_i, out_tok_ep3_i, desc_req_i, rx_valid_i, rx_valid_o;
    logic usb_clock_gate_o, pin_usb_sel_o, irq_o, seen, ack;
    logic [15:0] q;
    udci_pkg::udci_resp_t resp_o;
    udci_pkg::udci_event_t event_i;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;
    int sbit[4] = '{1, 2, 6, 7};
    udci_top u_udci_top (.core_clk_i, .reset_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i,
        .bus_rdata_o, .bus_ack_o, .tx_valid_i, .tx_data_i, .tx_ready_o, .in_tok_ep4_i, .out_tok_ep3_i,
        .desc_req_i, .rx_valid_i, .rx_data_i, .rx_valid_o, .rx_data_o(rx_byte), .resp_o, .event_i,
        .upper_irq_active_i, .usb_clock_gate_o, .pin_usb_sel_o, .gpio_pin_i, .gpio_pin_o, .gpio_pin_oe_o,
        .gpio_out_i, .gpio_oe_i, .gpio_in_o, .usb_pin_out_i, .usb_pin_oe_i, .usb_pin_in_o, .irq_o);
    udci_usb_host_model u_udci_usb_host_model (.core_clk_i, .rx_copy_i(rx_valid_o), .in_tok_o(in_tok_ep4_i),
        .out_tok_o(out_tok_ep3_i), .desc_req_o(desc_req_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .event_o(event_i));
    // Clock and hang guard
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One strobe cycle; answer taken at the following falling edge
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        bus_addr_i = a;
        bus_wdata_i = {8'h00, d};
        bus_wr_i = w;
        bus_rd_i = !w;
        @(negedge core_clk_i);
        bus_wr_i = 1'b0;
        bus_rd_i = 1'b0;
        q = bus_rdata_o;
        ack = bus_ack_o;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
        `CHK("write ack", 1'b1, ack)
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        acc(1'b0, a, 8'h00);
        `CHK("read ack", 1'b1, ack)
        `CHK("read data", e, q)
    endtask
    task automatic tok(input int k, input udci_pkg::udci_hs_t hs, input logic zl);
        u_udci_usb_host_model.send_token(k, seen);
        `CHK("resp valid", 1'b1, resp_o.valid)
        `CHK("resp hs", hs, resp_o.hs)
        `CHK("zero len", zl, resp_o.zero_len)
    endtask
    // Main sequence
    initial begin
        repeat (10) @(negedge core_clk_i);
        reset_i = 1'b0;
        `CHK("gate reset", 1'b0, usb_clock_gate_o)
        `CHK("ready reset", 1'b1, tx_ready_o)
        wr(`UDCI_OFF_CTRL, 8'h84);
        `CHK("gate on", 1'b1, usb_clock_gate_o)
        `CHK("gpio pins", 8'ha3, {gpio_pin_o, gpio_pin_oe_o})
        rd(`UDCI_OFF_CTRL, 16'h0084);
        rd(`UDCI_OFF_IEN, 16'h0000);
        rd(`UDCI_OFF_ISTS, 16'h0000);
        acc(1'b0, 16'h4030, 8'h00);
        `CHK("outside ack", 1'b0, ack)
        rd(16'h402e, 16'h0000);
        `CHK("usb pins", 8'h5f, {gpio_pin_o, gpio_pin_oe_o})
        gpio_pin_i = 4'h9;
        repeat (8) @(negedge core_clk_i);
        `CHK("usb pin in", 8'h90, {usb_pin_in_o, gpio_in_o})
        tok(0, udci_pkg::UDCI_HS_NAK, 1'b0);
        wr(`UDCI_OFF_CTRL, 8'hc4);
        tok(0, udci_pkg::UDCI_HS_ACK, 1'b1);
        rd(`UDCI_OFF_CTRL, 16'h0084);
        tok(2, udci_pkg::UDCI_HS_NAK, 1'b0);
        wr(`UDCI_OFF_CTRL, 8'hac);
        tok(1, udci_pkg::UDCI_HS_STALL, 1'b0);
        `CHK("stalled rx", 1'b0, seen)
        `CHK("stalled byte", 8'h00, rx_byte)
        rd(`UDCI_OFF_ISTS, 16'h0000);
        wr(`UDCI_OFF_CTRL, 8'ha4);
        tok(2, udci_pkg::UDCI_HS_ACK, 1'b0);
        tok(1, udci_pkg::UDCI_HS_ACK, 1'b0);
        `CHK("rx copy", 1'b1, seen)
        `CHK("rx byte", 8'ha5, rx_byte)
        `CHK("masked ep3", 1'b0, irq_o)
        rd(`UDCI_OFF_ISTS, 16'h0008);
        wr(`UDCI_OFF_ISTS, 8'h08);
        rd(`UDCI_OFF_ISTS, 16'h0000);
        // Fill the transmit buffer until it refuses
        for (n = 0; n < 40 && tx_ready_o === 1'b1; n++) begin
            tx_valid_i = 1'b1;
            tx_data_i = 8'(n);
            @(negedge core_clk_i);
        end
        tx_valid_i = 1'b0;
        `CHK("fifo words", 32, n)
        wr(`UDCI_OFF_CTRL, 8'hb4);
        tok(0, udci_pkg::UDCI_HS_STALL, 1'b0);
        `CHK("stall data", 1'b0, resp_o.has_data)
        wr(`UDCI_OFF_CTRL, 8'ha4);
        wr(`UDCI_OFF_IEN, 8'h10);
        // Drain it, three cycles between data tokens
        for (n = 0; n < 32; n++) begin
            tok(0, udci_pkg::UDCI_HS_ACK, 1'b0);
            `CHK("tx data", {1'b1, 8'(n)}, {resp_o.has_data, resp_o.data})
            `CHK("ep4 irq", 1'b1, irq_o)
            repeat (2) @(negedge core_clk_i);
        end
        tok(0, udci_pkg::UDCI_HS_NAK, 1'b0);
        rd(`UDCI_OFF_ISTS, 16'h0010);
        wr(`UDCI_OFF_ISTS, 8'h10);
        `CHK("ep4 clear", 1'b0, irq_o)
        // Each bus event: latch, zero-write kept, one-write clears
        wr(`UDCI_OFF_IEN, 8'hde);
        for (n = 0; n < 4; n++) begin
            u_udci_usb_host_model.pulse_event(n);
            `CHK("event irq", 1'b1, irq_o)
            wr(`UDCI_OFF_ISTS, 8'h00);
            rd(`UDCI_OFF_ISTS, 16'h0001 << sbit[n]);
            wr(`UDCI_OFF_ISTS, 8'h01 << sbit[n]);
            `CHK("event clear", 1'b0, irq_o)
        end
        wr(`UDCI_OFF_IEN, 8'h00);
        upper_irq_active_i = 1'b1;
        u_udci_usb_host_model.pulse_event(2);
        `CHK("masked sof", 1'b0, irq_o)
        rd(`UDCI_OFF_ISTS, 16'h0041);
        summarize();
    end
endmodule
